//--- tdp_burst_sched.sv
`timescale 1ns/1ps
`include "tdp_consts.svh"
module tdp_burst_sched import tdp_pkg::*; #(
  parameter logic [`TDP_CNT_W-1:0] P_SLOW = 32'h000b71b0, // slow burst spacing
  parameter logic [`TDP_CNT_W-1:0] P_FAST = 32'h00030d40  // confirm burst spacing
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_fast, // confirmation bursts pending
  output logic o_req // one-cycle burst request
);
  tdp_tmr_t st_r;
  tdp_tmr_t st_nxt;

  // countdown, reloaded at each request
  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (st_r.cnt == '0) begin
      st_nxt.pulse = 1'b1;
      st_nxt.cnt = (i_fast ? P_FAST : P_SLOW) - 32'h1;
    end else if (i_fast && st_r.cnt > P_FAST - 32'h1) begin
      // cut a running slow gap short once the integrator starts climbing
      st_nxt.cnt = P_FAST - 32'h1;
    end else begin
      st_nxt.cnt = st_r.cnt - 32'h1;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_req = st_r.pulse;
endmodule : tdp_burst_sched

//--- tdp_consts.svh
`ifndef TDP_CONSTS_SVH
`define TDP_CONSTS_SVH
// timing base and nominal intervals
`define TDP_CLK_KHZ 10000
`define TDP_MS_PER_S 1000
`define TDP_BURST_MS 75
`define TDP_CONFIRM_MS 20
`define TDP_PULSE_MS 75
`define TDP_SHORT_S 10
`define TDP_LONG_S 60
// sample and counter widths
`define TDP_SIG_W 16
`define TDP_CNT_W 32
// integrator and calibration
`define TDP_INTEG_LIMIT 3'h4
`define TDP_CAL_BURSTS 3'h4
`define TDP_CAL_SHIFT 2
// gain strap codes and threshold fraction shifts
`define TDP_GAIN_OPEN 2'h0
`define TDP_GAIN_MED 2'h1
`define TDP_GAIN_LOW 2'h2
`define TDP_SHIFT_HIGH 5
`define TDP_SHIFT_MED 4
`define TDP_SHIFT_LOW 3
// register byte offsets
`define TDP_OFS_STATUS 8'h00
`define TDP_OFS_SIGNAL 8'h04
`define TDP_OFS_REF 8'h08
`define TDP_OFS_THR 8'h0c
`define TDP_OFS_DROP 8'h10
`define TDP_OFS_DRIFT 8'h14
// drift register reset: divider, rise step, fall step
`define TDP_DRIFT_RST 24'h040108
`endif

//--- tdp_core.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "tdp_consts.svh"
module tdp_core import tdp_pkg::*; #(
  parameter logic [`TDP_CNT_W-1:0] P_BURST_CYC = `TDP_BURST_MS * `TDP_CLK_KHZ, // slow gap
  parameter logic [`TDP_CNT_W-1:0] P_CONFIRM_CYC = `TDP_CONFIRM_MS * `TDP_CLK_KHZ, // fast gap
  parameter logic [`TDP_CNT_W-1:0] P_PULSE_CYC = `TDP_PULSE_MS * `TDP_CLK_KHZ, // pulse width
  parameter logic [`TDP_CNT_W-1:0] P_SHORT_CYC =
    `TDP_SHORT_S * `TDP_MS_PER_S * `TDP_CLK_KHZ, // short limit
  parameter logic [`TDP_CNT_W-1:0] P_LONG_CYC =
    `TDP_LONG_S * `TDP_MS_PER_S * `TDP_CLK_KHZ // long limit
) (
  input wire logic I_CLK, // core clock, 10 MHz
  input wire logic I_SYS_RST, // sync reset, high
  input wire logic I_ADC_VALID, // burst result strobe
  input wire logic [`TDP_SIG_W-1:0] I_ADC_DATA, // burst result
  input wire logic [1:0] I_GAIN_STRAP, // gain strap level
  input wire logic I_MODE_STRAP_A, // first mode strap
  input wire logic I_MODE_STRAP_B, // second mode strap
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic I_PWRITE, // apb direction
  input wire logic [7:0] I_PADDR, // apb byte address
  input wire logic [31:0] I_PWDATA, // apb write data
  output logic [31:0] O_PRDATA, // apb read data
  output logic O_PREADY, // apb ready
  output logic O_PSLVERR, // apb error
  output logic O_BURST_REQ, // burst request pulse
  output logic O_DETECT, // detection in effect
  output logic O_OUT_N // sensor output, low active
);
  tdp_main_t st_r; // registered state
  tdp_main_t st_nxt; // next state
  logic burst_req; // from scheduler
  logic expire; // from on-duration timer
  logic fast; // confirmations pending
  logic long_lim; // long limit in force
  logic [`TDP_SIG_W-1:0] dlt; // threshold differential
  logic [`TDP_SIG_W:0] thr; // threshold, one bit headroom
  logic [`TDP_SIG_W:0] drop; // dropout level
  logic [`TDP_SIG_W:0] sig_x; // sample, widened
  logic [`TDP_SIG_W-1:0] fall_step; // reference fall step
  logic [`TDP_SIG_W-1:0] rise_step; // reference rise step
  logic [`TDP_SIG_W+1:0] cal_tot; // calibration total
  logic new_det; // detection just activated
  logic acc; // apb access phase
  logic [31:0] rd_val; // read mux value
  logic rd_ok; // mapped address

  // decode the two mode straps
  function automatic tdp_mode_t mode_dec(input logic a, input logic b);
    tdp_mode_t m;
    case ({a, b})
      2'h3: m = MD_LEVEL10;
      2'h2: m = MD_LEVEL60;
      2'h0: m = MD_TOGGLE;
      default: m = MD_PULSE;
    endcase
    return m;
  endfunction : mode_dec

  // threshold differential as a fraction of the reference level
  function automatic logic [`TDP_SIG_W-1:0] delta_of(
    input logic [`TDP_SIG_W-1:0] lvl,
    input logic [1:0] g
  );
    logic [`TDP_SIG_W-1:0] d;
    case (g)
      `TDP_GAIN_MED: d = lvl >> `TDP_SHIFT_MED;
      `TDP_GAIN_LOW: d = lvl >> `TDP_SHIFT_LOW;
      default: d = lvl >> `TDP_SHIFT_HIGH;
    endcase
    return d;
  endfunction : delta_of

  // burst pacing; fast while the integrator is climbing
  tdp_burst_sched #(
    .P_SLOW(P_BURST_CYC),
    .P_FAST(P_CONFIRM_CYC)
  ) u_sched (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_fast(fast),
    .o_req(burst_req)
  );

  // limit on one continuous detection
  tdp_ontime #(
    .P_SHORT(P_SHORT_CYC),
    .P_LONG(P_LONG_CYC)
  ) u_ontime (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_run(st_r.active),
    .i_long(long_lim),
    .o_expire(expire)
  );

  // helpers shared by the processes below
  always_comb begin
    fast = (st_r.state == ST_RUN) && !st_r.active && (st_r.integ != 3'h0);
    long_lim = (st_r.mode == MD_LEVEL60);
    dlt = delta_of(st_r.refl, st_r.gain);
    thr = {1'b0, st_r.refl} + {1'b0, dlt};
    drop = thr - {2'h0, dlt[`TDP_SIG_W-1:1]};
    sig_x = {1'b0, I_ADC_DATA};
    fall_step = {8'h0, st_r.drift[7:0]};
    rise_step = {8'h0, st_r.drift[15:8]};
    cal_tot = st_r.cal_sum + {2'h0, I_ADC_DATA};
  end

  // register read mux
  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    case (I_PADDR)
      // twelve status bits, the upper twenty read as zero
      `TDP_OFS_STATUS: rd_val = {20'h0, st_r.state, st_r.mode, st_r.gain,
                                 st_r.integ, st_r.toggle, st_r.active, st_r.out_n};
      `TDP_OFS_SIGNAL: rd_val = {16'h0, st_r.sig};
      `TDP_OFS_REF: rd_val = {16'h0, st_r.refl};
      `TDP_OFS_THR: rd_val = {15'h0, thr};
      `TDP_OFS_DROP: rd_val = {15'h0, drop};
      `TDP_OFS_DRIFT: rd_val = {8'h0, st_r.drift};
      default: begin
        rd_ok = 1'b0; // unmapped: error, zero data
      end
    endcase
  end

  // next-state logic of the detection core and bus slave
  always_comb begin
    st_nxt = st_r;
    new_det = 1'b0;
    acc = I_PSEL && I_PENABLE;
    // one wait state, then a one-cycle ready
    st_nxt.pready = acc && !st_r.pready;
    st_nxt.pslverr = acc && !st_r.pready && !rd_ok;
    st_nxt.prdata = (acc && !st_r.pready && !I_PWRITE) ? rd_val : 32'h0;
    if (acc && st_r.pready && I_PWRITE && I_PADDR == `TDP_OFS_DRIFT) begin
      st_nxt.drift = I_PWDATA[23:0]; // software sets slew rates
    end
    case (st_r.state)
      ST_LATCH: begin
        // first cycle after reset: freeze straps until next reset
        st_nxt.gain = I_GAIN_STRAP;
        st_nxt.mode = mode_dec(I_MODE_STRAP_A, I_MODE_STRAP_B);
        st_nxt.state = ST_CAL;
        st_nxt.cal_cnt = 3'h0;
        st_nxt.cal_sum = '0;
      end
      ST_CAL: begin
        // average a few bursts into a fresh reference
        if (I_ADC_VALID) begin
          st_nxt.sig = I_ADC_DATA;
          st_nxt.cal_sum = cal_tot;
          st_nxt.cal_cnt = st_r.cal_cnt + 3'h1;
          if (st_r.cal_cnt == `TDP_CAL_BURSTS - 3'h1) begin
            st_nxt.refl = cal_tot[`TDP_SIG_W+`TDP_CAL_SHIFT-1:`TDP_CAL_SHIFT];
            st_nxt.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (expire) begin
          // stuck detection: drop it and recalibrate
          st_nxt.state = ST_CAL;
          st_nxt.active = 1'b0;
          st_nxt.integ = 3'h0;
          st_nxt.cal_cnt = 3'h0;
          st_nxt.cal_sum = '0;
        end else if (I_ADC_VALID) begin
          st_nxt.sig = I_ADC_DATA;
          if (st_r.active) begin
            // hold on hysteresis; reference stays frozen meanwhile
            if (sig_x < drop) begin
              st_nxt.active = 1'b0;
              st_nxt.integ = 3'h0;
            end
          end else if (sig_x > thr) begin
            if (st_r.integ == `TDP_INTEG_LIMIT - 3'h1) begin
              st_nxt.integ = `TDP_INTEG_LIMIT;
              st_nxt.active = 1'b1;
              new_det = 1'b1;
            end else begin
              st_nxt.integ = st_r.integ + 3'h1;
            end
          end else begin
            st_nxt.integ = 3'h0;
            // drift only with no detection pending at all
            if (st_r.integ == 3'h0) begin
              if (I_ADC_DATA < st_r.refl) begin
                // falling signal: a full step every burst
                if (st_r.refl - I_ADC_DATA <= fall_step) begin
                  st_nxt.refl = I_ADC_DATA;
                end else begin
                  st_nxt.refl = st_r.refl - fall_step;
                end
              end else if (I_ADC_DATA > st_r.refl) begin
                // rising signal: one step every divider plus one bursts
                if (st_r.rise_cnt >= st_r.drift[23:16]) begin
                  st_nxt.rise_cnt = 8'h0;
                  if (I_ADC_DATA - st_r.refl <= rise_step) begin
                    st_nxt.refl = I_ADC_DATA;
                  end else begin
                    st_nxt.refl = st_r.refl + rise_step;
                  end
                end else begin
                  st_nxt.rise_cnt = st_r.rise_cnt + 8'h1;
                end
              end
            end
          end
        end
      end
      default: begin
        st_nxt.state = ST_LATCH;
      end
    endcase
    // output stage per mode
    if (new_det) begin
      st_nxt.toggle = !st_r.toggle;
    end
    if (new_det && st_r.mode == MD_PULSE) begin
      st_nxt.pulse_cnt = P_PULSE_CYC;
    end else if (st_r.pulse_cnt != '0) begin
      st_nxt.pulse_cnt = st_r.pulse_cnt - 32'h1;
    end
    case (st_r.mode)
      MD_TOGGLE: st_nxt.out_n = !st_nxt.toggle;
      MD_PULSE: st_nxt.out_n = (st_nxt.pulse_cnt == '0);
      default: st_nxt.out_n = !st_nxt.active;
    endcase
    // no output activity in the cycle that latches the straps
    if (st_r.state == ST_LATCH) begin
      st_nxt.out_n = 1'b1;
    end
  end

  // state register; reset only loads constants
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_r <= '0;
      st_r.drift <= `TDP_DRIFT_RST;
      st_r.out_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ports straight from the state register, burst request from the scheduler
  assign O_PRDATA = st_r.prdata;
  assign O_PREADY = st_r.pready;
  assign O_PSLVERR = st_r.pslverr;
  assign O_BURST_REQ = burst_req;
  assign O_DETECT = st_r.active;
  assign O_OUT_N = st_r.out_n;
endmodule : tdp_core

//--- tdp_core_monitor.sv
`timescale 1ns/1ps
module tdp_core_monitor (
  input wire logic I_CLK, // core clock
  input wire logic I_SYS_RST, // sync reset, high
  input wire logic I_ADC_VALID, // burst result strobe
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb enable
  input wire logic [7:0] I_PADDR, // apb byte address
  input wire logic [31:0] O_PRDATA, // apb read data
  input wire logic O_PREADY, // apb ready
  input wire logic O_PSLVERR, // apb error
  input wire logic O_BURST_REQ, // burst request pulse
  input wire logic O_DETECT, // detection in effect
  input wire logic O_OUT_N // sensor output, low active
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // slave answers after exactly one wait state
  a_ready_one_wait: assert property ($rose(I_PENABLE) && I_PSEL |=> O_PREADY)
    else $error("ready not one cycle after access start");
  a_ready_single: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error outside ready cycle");
  // only the six mapped words answer without error
  a_err_addr_map: assert property (O_PREADY |->
    O_PSLVERR == !(I_PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}))
    else $error("error flag disagrees with address map");
  a_rdata_idle_zero: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside ready cycle");
  a_burst_req_pulse: assert property (O_BURST_REQ |=> !O_BURST_REQ)
    else $error("burst request wider than one cycle");
  // calibration needs bursts straight after power-up
  a_first_burst: assert property ($fell(I_SYS_RST) |-> ##[0:3] O_BURST_REQ)
    else $error("no burst after reset release");
  // detection and output activation only follow a burst result
  a_detect_cause: assert property ($rose(O_DETECT) |->
    $past(I_ADC_VALID) || $past(I_ADC_VALID, 2))
    else $error("detect rose without burst result");
  a_out_cause: assert property ($fell(O_OUT_N) |->
    $past(I_ADC_VALID) || $past(I_ADC_VALID, 2))
    else $error("output fell without burst result");
  c_detect: cover property ($rose(O_DETECT));
  c_timeout: cover property ($fell(O_DETECT) && !$past(I_ADC_VALID));
  c_slverr: cover property (O_PSLVERR);
endmodule : tdp_core_monitor

bind tdp_core tdp_core_monitor u_mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_ADC_VALID(I_ADC_VALID), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_BURST_REQ(O_BURST_REQ), .O_DETECT(O_DETECT), .O_OUT_N(O_OUT_N));

//--- tdp_fe_model.sv
`timescale 1ns/1ps
`include "tdp_consts.svh"
module tdp_fe_model (
  input wire logic i_clk, // core clock
  input wire logic i_req, // burst request
  input wire logic [`TDP_SIG_W-1:0] i_level, // level the electrode shows
  input wire logic i_slow, // answer late
  output logic o_valid, // result strobe
  output logic [`TDP_SIG_W-1:0] o_data // result, scrambled off strobe
);
  int unsigned wait_r = 0; // cycles to answer, 0 when idle
  initial o_valid = 1'b0;
  initial o_data = 16'h5a5a;
  // one result per request; data flips each cycle so stale values never pass
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_req) begin
      wait_r <= i_slow ? 30 : 3;
    end else if (wait_r == 1) begin
      o_valid <= 1'b1;
      o_data <= i_level;
      wait_r <= 0;
    end else if (wait_r != 0) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule : tdp_fe_model

//--- tdp_ontime.sv
`timescale 1ns/1ps
`include "tdp_consts.svh"
module tdp_ontime import tdp_pkg::*; #(
  parameter logic [`TDP_CNT_W-1:0] P_SHORT = 32'h05f5e100, // short limit
  parameter logic [`TDP_CNT_W-1:0] P_LONG = 32'h23c34600  // long limit
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_run, // detection in effect
  input wire logic i_long, // long limit selected
  output logic o_expire // one-cycle timeout pulse
);
  tdp_tmr_t st_r;
  tdp_tmr_t st_nxt;
  logic [`TDP_CNT_W-1:0] lim;

  // up counter over one continuous detection
  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    lim = i_long ? P_LONG : P_SHORT;
    if (!i_run || st_r.pulse) begin
      st_nxt.cnt = '0; // restart on every new detection
    end else if (st_r.cnt >= lim - 32'h1) begin
      st_nxt.pulse = 1'b1;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_expire = st_r.pulse;
endmodule : tdp_ontime

//--- tdp_pkg.sv
`include "tdp_consts.svh"
package tdp_pkg;
  // sequencing of the detection core
  typedef enum logic [1:0] {ST_LATCH, ST_CAL, ST_RUN} tdp_state_t;
  // output behaviour picked by the mode straps
  typedef enum logic [1:0] {MD_LEVEL10, MD_LEVEL60, MD_TOGGLE, MD_PULSE} tdp_mode_t;
  // state of the detection core
  typedef struct packed {
    tdp_state_t state;
    logic [1:0] gain;
    tdp_mode_t mode;
    logic [`TDP_SIG_W-1:0] sig;
    logic [`TDP_SIG_W-1:0] refl;
    logic [2:0] integ;
    logic active;
    logic [2:0] cal_cnt;
    logic [`TDP_SIG_W+1:0] cal_sum;
    logic [7:0] rise_cnt;
    logic [23:0] drift;
    logic toggle;
    logic [`TDP_CNT_W-1:0] pulse_cnt;
    logic out_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tdp_main_t;
  // state of a down or up counter with one pulse output
  typedef struct packed {
    logic [`TDP_CNT_W-1:0] cnt;
    logic pulse;
  } tdp_tmr_t;
endpackage : tdp_pkg

//--- touch_detect_processing_tb.sv
`timescale 1ns/1ps
`include "tdp_consts.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module touch_detect_processing_tb import tdp_pkg::*;;
  logic clk = 1'b0; // core clock
  logic rst = 1'b1; // sync reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
  logic [7:0] paddr = 8'h0; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [1:0] gain = 2'h0; // gain strap
  logic sa = 1'b1, sb = 1'b1, slow = 1'b0; // mode straps, slow front end
  logic [15:0] level = 16'h03e8; // electrode level
  logic adc_valid, pready, pslverr, breq, det, out_n; // design handshakes
  logic [15:0] adc_data; // burst result
  logic [31:0] prdata, rd; // read data, last read
  logic er; // last error flag
  int n_mismatch = 0, check_count = 0, gap_cnt = 0, last_gap = 0, c;
  always #50 clk = ~clk;
  // spacing between burst results
  always @(posedge clk) begin
    if (adc_valid) begin
      last_gap <= gap_cnt;
      gap_cnt <= 1;
    end else gap_cnt <= gap_cnt + 1;
  end
  tdp_core #(.P_BURST_CYC(32'hc8), .P_CONFIRM_CYC(32'h32), .P_PULSE_CYC(32'h64),
    .P_SHORT_CYC(32'h7d0), .P_LONG_CYC(32'h1388)) DUT (.I_CLK(clk), .I_SYS_RST(rst),
    .I_ADC_VALID(adc_valid), .I_ADC_DATA(adc_data), .I_GAIN_STRAP(gain),
    .I_MODE_STRAP_A(sa), .I_MODE_STRAP_B(sb), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_BURST_REQ(breq), .O_DETECT(det),
    .O_OUT_N(out_n));
  tdp_fe_model u_fe (.i_clk(clk), .i_req(breq), .i_level(level), .i_slow(slow),
    .o_valid(adc_valid), .o_data(adc_data));
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // one apb transfer, held until ready is sampled
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk) begin psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; end
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin n_mismatch++; test_done(); end
  endtask : apb
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rchk
  // count burst results, then let outputs settle
  task bursts(input int n);
    int k;
    k = 0;
    while (n > 0) begin
      @(posedge clk);
      k++;
      if (adc_valid === 1'b1) n--;
      if (k > 4000) begin n_mismatch++; test_done(); end
    end
    repeat (3) @(posedge clk);
  endtask : bursts
  task wait_off;
    c = 0;
    while (det !== 1'b0 && c < 8000) begin @(posedge clk); c++; end
    if (c >= 8000) begin n_mismatch++; test_done(); end
  endtask : wait_off
  // power cycle; straps move after latching and must be ignored
  task por(input logic [1:0] g, input logic a, input logic b);
    @(posedge clk) begin rst <= 1'b1; gain <= g; sa <= a; sb <= b; level <= 16'h03e8; end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    gain <= ~g;
    sa <= ~a;
    sb <= ~b;
    bursts(4);
  endtask : por
  // every gain and mode code, register map and reset values
  task s_straps;
    logic [31:0] t;
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      por(i[1:0], !i[1], !(i[0] ^ i[1]));
      t = 32'h3e8 + (32'h3e8 >> ((i == 1) ? 4 : (i == 2) ? 3 : 5));
      apb(1'b0, `TDP_OFS_STATUS, 32'h0);
      `CHK("mode", i[1:0], rd[9:8])
      `CHK("gain", i[1:0], rd[7:6])
      rchk("ref", `TDP_OFS_REF, 32'h3e8);
      rchk("thr", `TDP_OFS_THR, t);
      rchk("drop", `TDP_OFS_DROP, t - ((t - 32'h3e8) >> 1));
      rchk("drift", `TDP_OFS_DRIFT, 32'h00040108);
    end
    apb(1'b1, `TDP_OFS_REF, 32'h1234);
    rchk("ref_ro", `TDP_OFS_REF, 32'h3e8);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, er)
    slow <= 1'b0;
  endtask : s_straps
  // level mode: integrator, hysteresis, timeout, drift
  task s_level;
    por(2'h0, 1'b1, 1'b1);
    apb(1'b1, `TDP_OFS_DRIFT, 32'h00ff0108);
    rchk("drift_rw", `TDP_OFS_DRIFT, 32'h00ff0108);
    bursts(2);
    `CHK("slow_gap", 200, last_gap)
    level <= 16'h044c;
    bursts(3);
    `CHK("det3", 1'b0, det)
    `CHK("confirm_gap", 1'b1, last_gap < 100)
    bursts(1);
    `CHK("det4", 1'b1, det)
    `CHK("out_on", 1'b0, out_n)
    level <= 16'h03fc;
    bursts(1);
    `CHK("hyst_hold", 1'b1, det)
    rchk("ref_frozen", `TDP_OFS_REF, 32'h3e8);
    level <= 16'h03f2;
    bursts(1);
    `CHK("dropout", 1'b0, det)
    `CHK("out_off", 1'b1, out_n)
    apb(1'b0, `TDP_OFS_STATUS, 32'h0);
    `CHK("integ_clr", 3'h0, rd[5:3])
    level <= 16'h044c;
    bursts(3);
    `CHK("fresh_run", 1'b0, det)
    bursts(1);
    wait_off();
    `CHK("timeout_10", 1'b1, c > 1500 && c < 2500)
    `CHK("out_release", 1'b1, out_n)
    bursts(4);
    rchk("recal", `TDP_OFS_REF, 32'h44c);
    level <= 16'h041a;
    bursts(1);
    rchk("fall", `TDP_OFS_REF, 32'h444);
    rchk("thr_follow", `TDP_OFS_THR, 32'h466);
    level <= 16'h0460;
    bursts(2);
    rchk("rise_slow", `TDP_OFS_REF, 32'h444);
  endtask : s_level
  task s_long;
    por(2'h0, 1'b1, 1'b0);
    level <= 16'h044c;
    bursts(4);
    wait_off();
    `CHK("timeout_60", 1'b1, c > 4000)
  endtask : s_long
  task s_toggle;
    por(2'h0, 1'b0, 1'b0);
    level <= 16'h044c;
    bursts(4);
    `CHK("tog_on", 1'b0, out_n)
    wait_off();
    `CHK("tog_limit", 1'b1, c < 2500)
    `CHK("tog_kept", 1'b0, out_n)
    bursts(4);
    level <= 16'h04b0;
    bursts(4);
    `CHK("tog_off", 1'b1, out_n)
  endtask : s_toggle
  task s_pulse;
    por(2'h0, 1'b0, 1'b1);
    level <= 16'h044c;
    bursts(4);
    `CHK("pulse_low", 1'b0, out_n)
    repeat (110) @(posedge clk);
    `CHK("pulse_end", 1'b1, out_n)
    `CHK("pulse_det", 1'b1, det)
  endtask : s_pulse
  initial begin
    s_straps();
    s_level();
    s_long();
    s_toggle();
    s_pulse();
    test_done();
  end
endmodule : touch_detect_processing_tb
